// ==== asr_pkg.sv ====
// Constants shared by the asynchronous serial receiver files.
// Assumes a 32-bit AXI4-Lite register bus and one 50 MHz clock.
`default_nettype none
package asr_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_BAUD = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0C;
  localparam logic [7:0] OFF_DATA = 8'h10;
  // Control register fields
  localparam int CTRL_RX_EN = 0;
  localparam int CTRL_IRQ_EN = 1;
  localparam int CTRL_PAR_EN = 2;
  localparam int CTRL_PAR_ODD = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // Status and mask register fields
  localparam int ST_RX_FULL = 0;
  localparam int ST_OVERRUN = 1;
  localparam int ST_PARITY = 2;
  localparam int ST_FRAMING = 3;
  localparam int ST_BUSY = 4;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;
  // Bit period in clock cycles; 434 cycles is about 115200 bit/s at 50 MHz
  localparam logic [15:0] BAUD_RESET = 16'h01B2;
  localparam logic [15:0] BAUD_MIN = 16'h0004;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Receive sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP
  } asr_state_t;
endpackage
`default_nettype wire

// ==== asr_rx_if.sv ====
// Link between the register side and the bit sampler of the receiver.
// Assumes both ends run on the same clock.
`default_nettype none
interface asr_rx_if;
  // Settings from the register side
  logic enable;
  logic par_en;
  logic par_odd;
  logic [15:0] divisor;
  // Character results from the sampler
  logic done;
  logic [7:0] data;
  logic par_err;
  logic stop_bit;
  logic busy;
  modport ctrl (output enable, par_en, par_odd, divisor,
                input done, data, par_err, stop_bit, busy);
  modport smp (input enable, par_en, par_odd, divisor,
               output done, data, par_err, stop_bit, busy);
endinterface
`default_nettype wire

// ==== asr_bit_sampler.sv ====
// Bit sampler: synchronises the serial line, finds start bits and
// shifts one character with optional parity and one stop bit.
// Assumes the line idles high and divisor is at least four cycles.
`default_nettype none
module asr_bit_sampler (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial line pin
  input wire logic rxd,
  // Register side link
  asr_rx_if.smp link
);
  // Three-stage synchroniser; only stage two reads stage one
  logic s1_q, s2_q, s3_q, line_q, line_d;
  // Sequencer state and counters
  asr_pkg::asr_state_t st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] shf_q, shf_d;
  logic perr_q, perr_d, done_q, done_d, stop_q, stop_d;

  // Line value changes only once stages two and three agree
  always_comb begin
    line_d = (s2_q == s3_q) ? s3_q : line_q;
  end

  // Sequencer next state
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    shf_d = shf_q;
    perr_d = perr_q;
    stop_d = stop_q;
    done_d = 1'b0;
    unique case (st_q)
      asr_pkg::ST_IDLE: begin
        // Falling line marks a start bit; wait half a bit
        if (link.enable && !line_q) begin
          st_d = asr_pkg::ST_START;
          cnt_d = {1'b0, link.divisor[15:1]};
          perr_d = 1'b0;
        end
      end
      asr_pkg::ST_START: begin
        if (cnt_q == 16'h0000) begin
          // A glitch shorter than half a bit is ignored
          st_d = line_q ? asr_pkg::ST_IDLE : asr_pkg::ST_DATA;
          cnt_d = link.divisor - 16'h0001;
          bit_d = 3'h0;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      asr_pkg::ST_DATA: begin
        if (cnt_q == 16'h0000) begin
          // Least significant bit arrives first
          shf_d = {line_q, shf_q[7:1]};
          cnt_d = link.divisor - 16'h0001;
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            st_d = link.par_en ? asr_pkg::ST_PAR : asr_pkg::ST_STOP;
          end
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      asr_pkg::ST_PAR: begin
        if (cnt_q == 16'h0000) begin
          // Parity good when data, parity bit and par_odd xor to zero
          perr_d = ^{shf_q, line_q, link.par_odd};
          cnt_d = link.divisor - 16'h0001;
          st_d = asr_pkg::ST_STOP;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      asr_pkg::ST_STOP: begin
        if (cnt_q == 16'h0000) begin
          // Stop bit sampled mid-bit, character handed on
          stop_d = line_q;
          done_d = 1'b1;
          st_d = asr_pkg::ST_IDLE;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      default: st_d = asr_pkg::ST_IDLE;
    endcase
    // Disabling the receiver abandons any character in progress
    if (!link.enable) begin
      st_d = asr_pkg::ST_IDLE;
    end
  end

  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      line_q <= 1'b1;
      st_q <= asr_pkg::ST_IDLE;
      cnt_q <= 16'h0000;
      bit_q <= 3'h0;
      shf_q <= 8'h00;
      perr_q <= 1'b0;
      stop_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      s1_q <= rxd;
      s2_q <= s1_q;
      s3_q <= s2_q;
      line_q <= line_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      shf_q <= shf_d;
      perr_q <= perr_d;
      stop_q <= stop_d;
      done_q <= done_d;
    end
  end

  assign link.done = done_q;
  assign link.data = shf_q;
  assign link.par_err = perr_q;
  assign link.stop_bit = stop_q;
  assign link.busy = (st_q != asr_pkg::ST_IDLE);

  // A start bit seen while idle and enabled starts the sequencer
  chk_start_sync: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == asr_pkg::ST_IDLE && link.enable && !line_q)
      |=> st_q == asr_pkg::ST_START)
    else $error("start bit did not start reception");
endmodule
`default_nettype wire

// ==== asr_rx_top.sv ====
// Receive path of an asynchronous serial interface with an AXI4-Lite
// register slave, sticky status flags and interrupt outputs.
// Assumes one clock aclk and a synchronous active-low reset.
//
// Summary of operation
// - Detect start bit, shift character, check parity/stop
// - Character done while full sets overrun flag
// - Overrun leaves the unread data register unchanged
// - Parity mismatch sets flag, data still copied
// - Zero stop bit sets framing flag, data copied
// - Any error with irq enable raises error irq
// - Good character copied, receive-full flag set
// - Good character with irq enable raises done irq
`default_nettype none
module asr_rx_top #(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial line pin
  input wire logic rxd,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Interrupts
  output logic irq,
  output logic rx_done_irq,
  output logic rx_error_irq
);
  // The sampler is built for eight-bit characters only
  if (DATA_W != 8) begin : g_bad_width
    $error("asr_rx_top supports DATA_W of 8 only");
  end

  asr_rx_if link ();

  asr_bit_sampler u_sampler (
    .aclk(aclk),
    .aresetn(aresetn),
    .rxd(rxd),
    .link(link)
  );

  // Software-visible state
  logic [3:0] ctrl_q, ctrl_d;
  logic [15:0] baud_q, baud_d;
  logic [3:0] status_q, status_d; // full, overrun, parity, framing
  logic [3:0] mask_q, mask_d;
  logic [7:0] rx_data_q, rx_data_d; // the receive data register
  // Bus slave state
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0] waddr_q, waddr_d;
  logic [31:0] wbuf_q, wbuf_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  // Interrupt outputs
  logic irq_q, irq_d, done_irq_q, done_irq_d, err_irq_q, err_irq_d;
  // Decoded write strobes
  logic wr_exec, wr_ok;
  logic [3:0] st_clr;

  // Byte offset decode, shared by the read and write paths
  function automatic logic addr_known(input logic [7:0] a);
    return a == asr_pkg::OFF_CTRL || a == asr_pkg::OFF_BAUD ||
           a == asr_pkg::OFF_STATUS || a == asr_pkg::OFF_MASK ||
           a == asr_pkg::OFF_DATA;
  endfunction

  // Settings to the sampler
  assign link.enable = ctrl_q[asr_pkg::CTRL_RX_EN];
  assign link.par_en = ctrl_q[asr_pkg::CTRL_PAR_EN];
  assign link.par_odd = ctrl_q[asr_pkg::CTRL_PAR_ODD];
  assign link.divisor = baud_q;

  // Bus slave: address and data are taken in either order
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    waddr_d = waddr_q;
    wbuf_d = wbuf_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (awvalid && awready_q) begin
      aw_have_d = 1'b1;
      waddr_d = awaddr;
    end
    if (wvalid && wready_q) begin
      w_have_d = 1'b1;
      wbuf_d = wdata;
      wstrb_d = wstrb;
    end
    // Response is issued once both halves are held
    if (wr_exec) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_ok ? asr_pkg::RESP_OKAY : asr_pkg::RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    // Read data is captured on the address handshake
    if (arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = addr_known(araddr) ? asr_pkg::RESP_OKAY
                                   : asr_pkg::RESP_SLVERR;
      unique case (araddr)
        asr_pkg::OFF_CTRL: rdata_d = {28'h0000000, ctrl_q};
        asr_pkg::OFF_BAUD: rdata_d = {16'h0000, baud_q};
        asr_pkg::OFF_STATUS: rdata_d = {27'h0000000, link.busy, status_q};
        asr_pkg::OFF_MASK: rdata_d = {28'h0000000, mask_q};
        asr_pkg::OFF_DATA: rdata_d = {24'h000000, rx_data_q};
        default: rdata_d = 32'h00000000;
      endcase
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    // One write and one read in flight at most
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  assign wr_exec = aw_have_q && w_have_q && !bvalid_q;
  assign wr_ok = addr_known(waddr_q);
  // Write-one-to-clear strobes for the status flags
  assign st_clr = (wr_exec && waddr_q == asr_pkg::OFF_STATUS &&
                   wstrb_q[0]) ? wbuf_q[3:0] : 4'h0;

  // Control, baud and mask registers; a short divisor is raised
  always_comb begin
    ctrl_d = ctrl_q;
    baud_d = baud_q;
    mask_d = mask_q;
    if (wr_exec && wstrb_q[0] && waddr_q == asr_pkg::OFF_CTRL) begin
      ctrl_d = wbuf_q[3:0];
    end
    if (wr_exec && waddr_q == asr_pkg::OFF_BAUD) begin
      if (wstrb_q[0]) begin
        baud_d[7:0] = wbuf_q[7:0];
      end
      if (wstrb_q[1]) begin
        baud_d[15:8] = wbuf_q[15:8];
      end
      if (baud_d < asr_pkg::BAUD_MIN) begin
        baud_d = asr_pkg::BAUD_MIN;
      end
    end
    if (wr_exec && wstrb_q[0] && waddr_q == asr_pkg::OFF_MASK) begin
      mask_d = wbuf_q[3:0];
    end
  end

  // Status flags and data register; a new event beats a same-cycle clear
  always_comb begin
    status_d = status_q & ~st_clr;
    rx_data_d = rx_data_q;
    if (link.done) begin
      if (status_q[asr_pkg::ST_RX_FULL]) begin
        // Unread character kept, new one dropped
        status_d[asr_pkg::ST_OVERRUN] = 1'b1;
      end else begin
        rx_data_d = link.data;
        if (link.par_err) begin
          status_d[asr_pkg::ST_PARITY] = 1'b1;
        end
        if (!link.stop_bit) begin
          status_d[asr_pkg::ST_FRAMING] = 1'b1;
        end
        if (!link.par_err && link.stop_bit) begin
          status_d[asr_pkg::ST_RX_FULL] = 1'b1;
        end
      end
    end
  end

  // Interrupt outputs follow the flags one cycle later
  always_comb begin
    irq_d = |(status_q & mask_q);
    // Done request while the data register holds a good character
    done_irq_d = ctrl_q[asr_pkg::CTRL_IRQ_EN] &&
                 status_q[asr_pkg::ST_RX_FULL];
    // Error request while any error flag stands
    err_irq_d = ctrl_q[asr_pkg::CTRL_IRQ_EN] &&
                |status_q[asr_pkg::ST_FRAMING:asr_pkg::ST_OVERRUN];
  end

  // All registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= asr_pkg::CTRL_RESET;
      baud_q <= asr_pkg::BAUD_RESET;
      status_q <= asr_pkg::STATUS_RESET;
      mask_q <= asr_pkg::MASK_RESET;
      rx_data_q <= 8'h00;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= 8'h00;
      wbuf_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= asr_pkg::RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= asr_pkg::RESP_OKAY;
      rdata_q <= 32'h00000000;
      irq_q <= 1'b0;
      done_irq_q <= 1'b0;
      err_irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      baud_q <= baud_d;
      status_q <= status_d;
      mask_q <= mask_d;
      rx_data_q <= rx_data_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      waddr_q <= waddr_d;
      wbuf_q <= wbuf_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      done_irq_q <= done_irq_d;
      err_irq_q <= err_irq_d;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign irq = irq_q;
  assign rx_done_irq = done_irq_q;
  assign rx_error_irq = err_irq_q;

  // Checks on character hand-over
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_over;
    link.done && status_q[asr_pkg::ST_RX_FULL];
  endsequence
  sequence s_good;
    link.done && !status_q[asr_pkg::ST_RX_FULL] && !link.par_err &&
    link.stop_bit;
  endsequence

  chk_overrun_set: assert property (s_over |=> status_q[1])
    else $error("overrun not flagged");
  chk_overrun_keep: assert property (
    s_over |=> rx_data_q == $past(rx_data_q))
    else $error("data register overwritten on overrun");
  chk_parity_copy: assert property (
    link.done && !status_q[0] && link.par_err
      |=> status_q[2] && rx_data_q == $past(link.data))
    else $error("parity error not flagged or data lost");
  chk_framing_copy: assert property (
    link.done && !status_q[0] && !link.stop_bit
      |=> status_q[3] && rx_data_q == $past(link.data))
    else $error("framing error not flagged or data lost");
  chk_error_irq: assert property (
    s_over ##0 ctrl_q[1] |=> ##1 rx_error_irq)
    else $error("error interrupt missing");
  chk_good_copy: assert property (
    s_good |=> status_q[0] && rx_data_q == $past(link.data))
    else $error("good character not stored");
  chk_done_irq: assert property (
    s_good ##0 ctrl_q[1] |=> ##1 rx_done_irq && !rx_error_irq)
    else $error("done interrupt missing");
  chk_flag_hold: assert property (
    status_q[0] && !st_clr[0] |=> status_q[0])
    else $error("receive-full dropped without clear");
endmodule
`default_nettype wire

// ==== asr_tx_model.sv ====
// Model of the remote transmitter that feeds the serial receiver.
// Assumes the line idles high and the caller gives the bit period.
`default_nettype none
module asr_tx_model (
  // Clock
  input wire logic aclk,
  // Serial line toward the receiver
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  // Line rests high between frames
  initial rxd = 1'b1;
  // One bit held a whole period, changed just after an edge
  task automatic put_bit(input logic b, input int n);
    rxd <= b;
    repeat (n) @(posedge aclk);
  endtask
  // Start, eight data bits LSB first, optional parity, one stop bit
  task automatic send(input logic [7:0] d, input logic par_en,
      input logic odd, input logic bad_par, input logic stop,
      input int n);
    @(posedge aclk);
    put_bit(1'b0, n);
    for (int i = 0; i < 8; i++) begin
      put_bit(d[i], n);
    end
    // Parity makes the ones count even, or odd when odd is set
    if (par_en) begin
      put_bit((^d) ^ odd ^ bad_par, n);
    end
    if (stop) begin
      put_bit(1'b1, n);
    end else begin
      // Low stop cut short so its tail cannot pass for a start
      put_bit(1'b0, n - 2);
      put_bit(1'b1, 2);
    end
  endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the serial receiver with its register bus.
// Assumes the transmitter model drives the line and reads are checked
// by a watcher process against a queue of expected answers.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT_CYC = 8; // Short bit period keeps the run brief
  logic aclk, aresetn, rxd;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, b0, b1;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic irq, rx_done_irq, rx_error_irq;
  int num_errors, n_tests;
  logic [33:0] exp_q[$]; // Expected {resp, data}, oldest first
  logic [1:0] expb_q[$]; // Expected write responses, oldest first

  asr_rx_top dut (.aclk(aclk), .aresetn(aresetn), .rxd(rxd),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .irq(irq), .rx_done_irq(rx_done_irq),
    .rx_error_irq(rx_error_irq));
  asr_tx_model tx (.aclk(aclk), .rxd(rxd));

  // Free-running 50 MHz clock
  initial aclk = 1'b0;
  always #10 aclk = ~aclk;

  // Compare one value, count it, report a mismatch at once
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h",
        $time, seen, exp);
    end
  endtask

  // Verdict and end of run; the only exit
  task automatic report_and_stop;
    // An answer that never came leaves its note behind
    if (exp_q.size() + expb_q.size() != 0) begin
      num_errors++;
    end
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Write: both halves offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r = asr_pkg::RESP_OKAY);
    logic aw_ok, w_ok;
    expb_q.push_back(r);
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  // Read: note the expected answer, then run the handshake
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r = asr_pkg::RESP_OKAY);
    exp_q.push_back({r, d});
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // Watcher: every read answer against the oldest note
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      if (exp_q.size() > 0) begin
        check({rresp, rdata}, exp_q.pop_front());
      end else begin
        num_errors++;
      end
    end
    // Write responses against their own notes
    if (bvalid === 1'b1 && bready === 1'b1) begin
      if (expb_q.size() > 0) begin
        check({32'h0, bresp}, {32'h0, expb_q.pop_front()});
      end else begin
        num_errors++;
      end
    end
  end

  // Interrupt lines as {done, error, combined}, after their lag
  task automatic irq_chk(input logic [2:0] e);
    repeat (2) @(posedge aclk);
    check({31'h0, rx_done_irq, rx_error_irq, irq}, {31'h0, e});
  endtask

  // One character on the line, then time for flags to settle
  task automatic rx_char(input logic [7:0] d, input logic pe,
      input logic odd, input logic bad, input logic stop);
    tx.send(d, pe, odd, bad, stop, BIT_CYC);
    repeat (6) @(posedge aclk);
  endtask

  // Watchdog: far beyond the thousand or so cycles the tests need
  initial begin
    #600us;
    num_errors++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    num_errors = 0;
    n_tests = 0;
    void'($urandom(32'h2EC4208B));
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // Reset values and an unmapped place
    rd(asr_pkg::OFF_CTRL, 32'h0);
    rd(asr_pkg::OFF_BAUD, 32'h1B2);
    rd(asr_pkg::OFF_STATUS, 32'h0);
    rd(asr_pkg::OFF_MASK, 32'h0);
    rd(asr_pkg::OFF_DATA, 32'h0);
    rd(8'h14, 32'h0, asr_pkg::RESP_SLVERR);
    wr(8'h14, 32'h5A, asr_pkg::RESP_SLVERR);
    // A divisor too short to sample is raised to the floor
    wr(asr_pkg::OFF_BAUD, 32'h1);
    rd(asr_pkg::OFF_BAUD, {16'h0, asr_pkg::BAUD_MIN});
    wr(asr_pkg::OFF_BAUD, 32'(BIT_CYC));
    wr(asr_pkg::OFF_MASK, 32'hF);
    wr(asr_pkg::OFF_CTRL, 32'h3);
    // Clean character
    rx_char(b0, 1'b0, 1'b0, 1'b0, 1'b1);
    rd(asr_pkg::OFF_DATA, {24'h0, b0});
    rd(asr_pkg::OFF_STATUS, 32'h1);
    irq_chk(3'b101);
    // Second character while still full is lost
    rx_char(b1, 1'b0, 1'b0, 1'b0, 1'b1);
    rd(asr_pkg::OFF_DATA, {24'h0, b0});
    rd(asr_pkg::OFF_STATUS, 32'h3);
    irq_chk(3'b111);
    // Clearing one flag leaves the other standing
    wr(asr_pkg::OFF_STATUS, 32'h2);
    rd(asr_pkg::OFF_STATUS, 32'h1);
    wr(asr_pkg::OFF_STATUS, 32'hF);
    irq_chk(3'b000);
    // Bad then good parity in both senses
    for (int odd = 0; odd < 2; odd++) begin
      wr(asr_pkg::OFF_CTRL, 32'h7 | 32'(odd << 3));
      rx_char(b1, 1'b1, odd[0], 1'b1, 1'b1);
      rd(asr_pkg::OFF_STATUS, 32'h4);
      rd(asr_pkg::OFF_DATA, {24'h0, b1});
      irq_chk(3'b011);
      wr(asr_pkg::OFF_STATUS, 32'hF);
      rx_char(b0, 1'b1, odd[0], 1'b0, 1'b1);
      rd(asr_pkg::OFF_STATUS, 32'h1);
      wr(asr_pkg::OFF_STATUS, 32'hF);
    end
    // Low stop bit
    wr(asr_pkg::OFF_CTRL, 32'h3);
    rx_char(b1, 1'b0, 1'b0, 1'b0, 1'b0);
    rd(asr_pkg::OFF_STATUS, 32'h8);
    rd(asr_pkg::OFF_DATA, {24'h0, b1});
    irq_chk(3'b011);
    wr(asr_pkg::OFF_STATUS, 32'hF);
    // No receive interrupt enable, mask off, then mask on
    wr(asr_pkg::OFF_CTRL, 32'h1);
    wr(asr_pkg::OFF_MASK, 32'h0);
    // Busy reads back while a character is still on the line
    fork
      tx.send(b0, 1'b0, 1'b0, 1'b0, 1'b1, BIT_CYC);
      begin
        repeat (30) @(posedge aclk);
        rd(asr_pkg::OFF_STATUS, 32'h10);
      end
    join
    repeat (6) @(posedge aclk);
    irq_chk(3'b000);
    wr(asr_pkg::OFF_MASK, 32'h1);
    irq_chk(3'b001);
    report_and_stop;
  end
endmodule
`default_nettype wire
